// file: rtl/pbc_selector.sv
// PLL control registers, base clock source selection with transition hold,
// divide-by-two output, lock change flag and interrupt.
// Assumes crystal and VCO clocks arrive as levels synchronous to i_clock.
`timescale 1ns/1ps

// Summary of operation
// - Reference divider or multiplier programmed zero acts as one.
// - Linear range zero disables PLL and forces crystal clock as source.
// - Switchover waits three crystal and three VCO clock cycles.
// - Base clock output stays static during a switchover.
// - Selected source is divided by two after the transition logic.
// - Select bit set chooses VCO clock, clear chooses crystal clock.
// - VCO clock cannot be selected while PLL power is off.
// - PLL power cannot be cleared while VCO clock is selected.
// - Power change combined with select change in one write is ignored.
// - Oscillator and PLL are enabled by the system oscillator enable.
// - Run-in-stop bit keeps oscillator running; default follows system enable.
// - Base clock output has even duty at half the source rate.
// - Crystal clock is divided by two like the VCO clock, straight from the oscillator.
// - Interrupt line is driven by the lock detection logic.
// - Centre frequency is L times two to the E times 38.4 kHz.
// - Lock flag sets on each lock toggle while automatic bandwidth is on, cleared by control reads.
// - Without automatic bandwidth, flag and lock read zero, enable forced clear.
// - PLL programming registers ignore writes while PLL power is on.
module pbc_selector #(
  parameter int SWITCH_EDGES = pbc_pkg::SWITCH_EDGES_D
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Clock sources and analog status
  input  wire logic        i_crystal_clock,
  input  wire logic        i_vco_clock,
  input  wire logic        i_lock_detect,
  input  wire logic        i_filter_tracking,
  input  wire logic        i_osc_enable_from_sysint,
  // Clock and control outputs
  output logic             o_base_clock_out,
  output logic             o_clock_unit_irq,
  output logic             o_osc_enable,
  output logic             o_pll_enable,
  output logic             o_acq_mode,
  output logic      [1:0]  o_prescale_p,
  output logic      [1:0]  o_vco_range_e,
  output logic      [11:0] o_multiplier_n,
  output logic      [7:0]  o_linear_range,
  output logic      [3:0]  o_ref_divider,
  output logic      [31:0] o_vco_centre_hz
);
  import pbc_pkg::*;

  if (SWITCH_EDGES < 1 || SWITCH_EDGES > 3) begin : g_check
    $error("SWITCH_EDGES must be 1 to 3");
  end

  localparam logic [1:0] EDGES = 2'(SWITCH_EDGES);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] idx);
    hits = (addr == 8'(idx << 2));
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr[7:2] >= IDX_PLL_CONTROL[5:0])
             && (addr[7:2] <= IDX_OSC_CONFIG[5:0]);
  endfunction

  pbc_regs_type q;
  pbc_regs_type d;

  logic wr_done;
  logic rd_done;
  logic setup;
  logic xrise;
  logic vrise;
  logic src_rise;

  assign setup    = i_psel && !i_penable;
  assign wr_done  = i_psel && i_penable && q.pready && i_pwrite;
  assign rd_done  = i_psel && i_penable && q.pready && !i_pwrite;
  assign xrise    = i_crystal_clock && !q.xclk_prev;
  assign vrise    = i_vco_clock && !q.vclk_prev;
  assign src_rise = q.active_sel ? vrise : xrise;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic want_on;
    logic want_bcs;
    logic combined;
    logic toggle;
    want_on  = i_pwdata[CTL_ON_BIT];
    want_bcs = i_pwdata[CTL_BCS_BIT];
    combined = 1'b0;
    toggle   = 1'b0;
    d        = q;

    // APB answer prepared during setup, one access cycle
    d.pready  = setup;
    d.pslverr = setup && !mapped(i_paddr);
    d.prdata  = 32'h0000_0000;
    if (setup) begin
      if (hits(i_paddr, IDX_PLL_CONTROL)) begin
        d.prdata[7:0] = {q.ie && q.auto_bw, q.flag && q.auto_bw, q.pll_power_on, q.base_clock_select,
                         q.pre, q.vco_range_power_field};
      end else if (hits(i_paddr, IDX_BANDWIDTH)) begin
        d.prdata[7:0] = {q.auto_bw, q.lock && q.auto_bw, q.acq, 5'h00};
      end else if (hits(i_paddr, IDX_MULT_HIGH)) begin
        d.prdata[7:0] = {4'h0, q.mul[11:8]};
      end else if (hits(i_paddr, IDX_MULT_LOW)) begin
        d.prdata[7:0] = q.mul[7:0];
      end else if (hits(i_paddr, IDX_VCO_RANGE)) begin
        d.prdata[7:0] = q.vrs;
      end else if (hits(i_paddr, IDX_REF_DIVIDER)) begin
        d.prdata[7:0] = {4'h0, q.rds};
      end else if (hits(i_paddr, IDX_OSC_CONFIG)) begin
        d.prdata[7:0] = {7'h00, q.run_in_stop};
      end
    end

    // Register writes
    if (wr_done) begin
      if (hits(i_paddr, IDX_PLL_CONTROL)) begin
        d.ie     = i_pwdata[CTL_IE_BIT];
        combined = (want_on != q.pll_power_on) && (want_bcs != q.base_clock_select);
        if (!combined) begin
          d.pll_power_on = want_on || q.base_clock_select;
          d.base_clock_select   = want_bcs && q.pll_power_on && (q.vrs != 8'h00);
        end
        if (!q.pll_power_on) begin
          d.pre = i_pwdata[CTL_PRE_LSB+1:CTL_PRE_LSB];
          d.vco_range_power_field = i_pwdata[1:0];
        end
      end else if (hits(i_paddr, IDX_BANDWIDTH)) begin
        d.auto_bw = i_pwdata[BW_AUTO_BIT];
        if (!q.auto_bw) begin
          d.acq = i_pwdata[BW_ACQ_BIT];
        end
      end else if (hits(i_paddr, IDX_OSC_CONFIG)) begin
        d.run_in_stop = i_pwdata[CFG_RIS_BIT];
      end else if (!q.pll_power_on) begin
        if (hits(i_paddr, IDX_MULT_HIGH)) begin
          d.mul[11:8] = i_pwdata[3:0];
        end else if (hits(i_paddr, IDX_MULT_LOW)) begin
          d.mul[7:0] = i_pwdata[7:0];
        end else if (hits(i_paddr, IDX_VCO_RANGE)) begin
          d.vrs = i_pwdata[7:0];
        end else if (hits(i_paddr, IDX_REF_DIVIDER)) begin
          d.rds = i_pwdata[3:0];
        end
      end
    end
    if (d.vrs == 8'h00) begin
      d.base_clock_select = 1'b0;
    end
    if (!d.auto_bw) begin
      d.ie = 1'b0;
    end else begin
      d.acq = i_filter_tracking;
    end

    // Lock change flag, a set beats a clearing read
    d.lock = i_lock_detect;
    toggle = q.auto_bw && (i_lock_detect != q.lock);
    d.flag = toggle || (q.flag && !(rd_done && hits(i_paddr, IDX_PLL_CONTROL)));
    d.irq  = d.flag && d.ie && d.auto_bw;

    // Source switchover and divider
    d.xclk_prev = i_crystal_clock;
    d.vclk_prev = i_vco_clock;
    case (q.state)
      ST_RUN: begin
        if (src_rise) begin
          d.base = !q.base;
        end
        if (q.base_clock_select != q.active_sel) begin
          d.state = ST_HOLD;
          d.xcnt  = 2'h0;
          d.vcnt  = 2'h0;
        end
      end
      ST_HOLD: begin
        if (xrise && q.xcnt != EDGES) begin
          d.xcnt = q.xcnt + 2'h1;
        end
        if (vrise && q.vcnt != EDGES) begin
          d.vcnt = q.vcnt + 2'h1;
        end
        if (q.xcnt == EDGES && q.vcnt == EDGES) begin
          d.active_sel = q.base_clock_select;
          d.state      = ST_RUN;
        end
      end
      default: begin
        d.state = ST_RUN;
      end
    endcase

    // Derived outputs
    d.osc_en = i_osc_enable_from_sysint || d.run_in_stop;
    d.pll_en = d.pll_power_on && (d.vrs != 8'h00) && d.osc_en;
    d.eff_n  = (d.mul == 12'h000) ? 12'h001 : d.mul;
    d.eff_r  = (d.rds == 4'h0) ? 4'h1 : d.rds;
    d.centre = ({24'h00_0000, d.vrs} * NOM_STEP_HZ) << d.vco_range_power_field;
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_prdata         = q.prdata;
  assign o_pready         = q.pready;
  assign o_pslverr        = q.pslverr;
  assign o_base_clock_out = q.base;
  assign o_clock_unit_irq = q.irq;
  assign o_osc_enable     = q.osc_en;
  assign o_pll_enable     = q.pll_en;
  assign o_acq_mode       = q.acq;
  assign o_prescale_p     = q.pre;
  assign o_vco_range_e    = q.vco_range_power_field;
  assign o_multiplier_n   = q.eff_n;
  assign o_linear_range   = q.vrs;
  assign o_ref_divider    = q.eff_r;
  assign o_vco_centre_hz  = q.centre;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_enter_hold;
    q.state == ST_RUN && q.base_clock_select != q.active_sel;
  endsequence

  sequence s_hold_frozen;
    q.state == ST_HOLD ##1 $stable(o_base_clock_out);
  endsequence

  AST_HOLD_FROZEN: assert property (s_enter_hold |=> ##1 s_hold_frozen)
    else $error("Base clock moved during switchover");
  AST_SELECT_NEEDS_ON: assert property (q.base_clock_select |-> q.pll_power_on)
    else $error("VCO selected with PLL off");
  AST_RANGE_ZERO: assert property (q.vrs == 8'h00 |-> !q.base_clock_select && !o_pll_enable)
    else $error("Zero range left PLL usable");
  AST_ZERO_AS_ONE: assert property (q.mul == 12'h000 |-> o_multiplier_n == 12'h001)
    else $error("Zero multiplier not read as one");
  AST_COMBINED_IGNORED: assert property (wr_done && hits(i_paddr, IDX_PLL_CONTROL)
      && i_pwdata[CTL_ON_BIT] != q.pll_power_on && i_pwdata[CTL_BCS_BIT] != q.base_clock_select
      |=> $stable(q.pll_power_on) && $stable(q.base_clock_select))
    else $error("Combined power and select change accepted");
  AST_LOCKED_WHILE_ON: assert property (wr_done && q.pll_power_on
      && hits(i_paddr, IDX_VCO_RANGE) |=> $stable(q.vrs))
    else $error("Range written while PLL on");
  AST_FLAG_ON_TOGGLE: assert property ($past(q.auto_bw) && $changed(q.lock) |-> q.flag)
    else $error("Lock toggle did not set flag");
  AST_IRQ_GATED: assert property (!q.auto_bw |-> !o_clock_unit_irq)
    else $error("Interrupt without automatic bandwidth");
  AST_DIVIDE: assert property ($changed(o_base_clock_out)
      |-> $past(q.state) == ST_RUN && $past(src_rise))
    else $error("Base clock edge without source edge");
  AST_NO_OFF_SELECTED: assert property (q.base_clock_select |=> q.pll_power_on)
    else $error("PLL turned off while VCO selected");
  AST_HOLD_STATIC: assert property (q.state == ST_HOLD |=> $stable(o_base_clock_out))
    else $error("Base clock moved while holding");
  AST_ZERO_DIV_AS_ONE: assert property (q.rds == 4'h0 |-> o_ref_divider == 4'h1)
    else $error("Zero divider not read as one");
  AST_RUN_IN_STOP: assert property (q.run_in_stop |-> o_osc_enable)
    else $error("Oscillator stopped with run-in-stop set");
  AST_PLL_NEEDS_OSC: assert property (o_pll_enable |-> o_osc_enable)
    else $error("PLL enabled without oscillator enable");
  AST_IRQ_FOLLOWS: assert property (o_clock_unit_irq |-> q.flag && q.ie)
    else $error("Interrupt without flag and enable");
  AST_FLAG_SET_WINS: assert property (q.auto_bw && i_lock_detect != q.lock |=> q.flag)
    else $error("Lock toggle lost against clearing read");
  AST_FLAG_READ_CLEAR: assert property (rd_done && hits(i_paddr, IDX_PLL_CONTROL)
      && !(q.auto_bw && i_lock_detect != q.lock) |=> !q.flag)
    else $error("Control read did not clear lock flag");

endmodule

// file: rtl/pbc_pkg.sv
// Package for the PLL base clock selector: register map, fields, resets, states.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
package pbc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_PLL_CONTROL  = 8'h36;
  localparam logic [7:0] IDX_BANDWIDTH    = 8'h37;
  localparam logic [7:0] IDX_MULT_HIGH    = 8'h38;
  localparam logic [7:0] IDX_MULT_LOW     = 8'h39;
  localparam logic [7:0] IDX_VCO_RANGE    = 8'h3A;
  localparam logic [7:0] IDX_REF_DIVIDER  = 8'h3B;
  localparam logic [7:0] IDX_OSC_CONFIG   = 8'h3C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL_IE_BIT    = 7;
  localparam int CTL_FLAG_BIT  = 6;
  localparam int CTL_ON_BIT    = 5;
  localparam int CTL_BCS_BIT   = 4;
  localparam int CTL_PRE_LSB   = 2;
  localparam int BW_AUTO_BIT   = 7;
  localparam int BW_LOCK_BIT   = 6;
  localparam int BW_ACQ_BIT    = 5;
  localparam int CFG_RIS_BIT   = 0;

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [11:0] MULT_RESET     = 12'h040;
  localparam logic [7:0]  RANGE_RESET    = 8'h40;
  localparam logic [3:0]  REFDIV_RESET   = 4'h1;
  localparam logic [31:0] NOM_STEP_HZ    = 32'h0000_9600;
  localparam int          SWITCH_EDGES_D = 3;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } pbc_state_type;

  typedef struct packed {
    logic          ie;
    logic          flag;
    logic          pll_power_on;
    logic          base_clock_select;
    logic [1:0]    pre;
    logic [1:0]    vco_range_power_field;
    logic          auto_bw;
    logic          acq;
    logic [11:0]   mul;
    logic [7:0]    vrs;
    logic [3:0]    rds;
    logic          run_in_stop;
    logic          lock;
    logic          xclk_prev;
    logic          vclk_prev;
    logic          active_sel;
    pbc_state_type state;
    logic [1:0]    xcnt;
    logic [1:0]    vcnt;
    logic          base;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    logic          pll_en;
    logic          osc_en;
    logic [11:0]   eff_n;
    logic [3:0]    eff_r;
    logic [31:0]   centre;
  } pbc_regs_type;

  localparam pbc_regs_type REGS_RESET = '{
    ie: 1'b0, flag: 1'b0, pll_power_on: 1'b1, base_clock_select: 1'b0, pre: 2'h0, vco_range_power_field: 2'h0,
    auto_bw: 1'b0, acq: 1'b0, mul: MULT_RESET, vrs: RANGE_RESET,
    rds: REFDIV_RESET, run_in_stop: 1'b0, lock: 1'b0, xclk_prev: 1'b0,
    vclk_prev: 1'b0, active_sel: 1'b0, state: ST_RUN, xcnt: 2'h0,
    vcnt: 2'h0, base: 1'b0, prdata: 32'h0000_0000, pready: 1'b0,
    pslverr: 1'b0, irq: 1'b0, pll_en: 1'b0, osc_en: 1'b0,
    eff_n: MULT_RESET, eff_r: REFDIV_RESET, centre: 32'h0000_0000
  };

endpackage

// file: bench/pbc_clock_partner.sv
// Far side model: crystal oscillator and VCO levels seen by the selector.
// Assumes one system clock; the levels change just after its rising edge.
`timescale 1ns/1ps
module pbc_clock_partner #(
  parameter int X_HALF = 2,
  parameter int V_HALF = 3
) (
  // System clock
  input  wire logic i_clock,
  // Enables from the selector
  input  wire logic i_osc_enable,
  input  wire logic i_pll_enable,
  // Source clock levels
  output logic      o_crystal_clock,
  output logic      o_vco_clock
);
  // ************************************************************
  // Sources stand still while disabled
  // ************************************************************
  int   xcnt   = 0;
  int   vcnt   = 0;
  logic xclk_q = 1'b0;
  logic vclk_q = 1'b0;
  assign o_crystal_clock = xclk_q;
  assign o_vco_clock     = vclk_q;
  always @(posedge i_clock) begin
    if (i_osc_enable === 1'b1) begin
      xcnt <= (xcnt == X_HALF - 1) ? 0 : xcnt + 1;
      if (xcnt == X_HALF - 1) begin
        xclk_q <= ~xclk_q;
      end
    end
    if (i_osc_enable === 1'b1 && i_pll_enable === 1'b1) begin
      vcnt <= (vcnt == V_HALF - 1) ? 0 : vcnt + 1;
      if (vcnt == V_HALF - 1) begin
        vclk_q <= ~vclk_q;
      end
    end
  end
endmodule

// file: bench/pbc_selector_test.sv
// Testbench for the PLL base clock selector, driven over APB.
// Assumes the partner model supplies crystal (period 4) and VCO (period 6) levels.
`timescale 1ns/1ps
module pbc_selector_test;
  import pbc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        xclk;
  logic        vclk;
  logic        lock;
  logic        sysen;
  logic        base;
  logic        irq;
  logic        osc_en;
  logic        pll_en;
  logic [1:0]  range_e;
  logic [11:0] mult_n;
  logic [3:0]  ref_r;
  logic [31:0] centre;
  logic        acq;
  logic [1:0]  pre_p;
  logic [7:0]  lin_l;
  logic        track;
  logic        last_base = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          toggles = 0;
  int          miscompares;
  int          n_compared;

  pbc_selector #(.SWITCH_EDGES(3)) dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_crystal_clock(xclk),
    .i_vco_clock(vclk), .i_lock_detect(lock), .i_filter_tracking(track),
    .i_osc_enable_from_sysint(sysen), .o_base_clock_out(base),
    .o_clock_unit_irq(irq), .o_osc_enable(osc_en), .o_pll_enable(pll_en),
    .o_acq_mode(acq), .o_prescale_p(pre_p), .o_vco_range_e(range_e),
    .o_multiplier_n(mult_n), .o_linear_range(lin_l), .o_ref_divider(ref_r),
    .o_vco_centre_hz(centre)
  );

  pbc_clock_partner #(.X_HALF(2), .V_HALF(3)) u_partner (
    .i_clock(clk), .i_osc_enable(osc_en), .i_pll_enable(pll_en),
    .o_crystal_clock(xclk), .o_vco_clock(vclk)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Counts base clock edges over n cycles
  task automatic rate(input int n, input int exp);
    int s;
    s = toggles;
    tick(n);
    check(32'(toggles - s), 32'(exp));
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    last_base <= base;
    if (base !== last_base) toggles <= toggles + 1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lock = 1'b0;
    sysen = 1'b1;
    track = 1'b0;
    miscompares = 0;
    n_compared = 0;
    tick(3);
    rst_n <= 1'b1;
    rdchk(IDX_PLL_CONTROL, 32'h0000_0020);
    rdchk(IDX_MULT_LOW, 32'h0000_0040);
    rdchk(IDX_VCO_RANGE, 32'h0000_0040);
    rdchk(IDX_REF_DIVIDER, 32'h0000_0001);
    apb(1'b0, 8'h3F, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    tick(8);
    rate(48, 12);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0030);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0030);
    rate(8, 0);
    tick(40);
    rate(48, 8);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0010);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0030);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0000);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0030);
    apb(1'b1, IDX_MULT_LOW, 32'h0000_0000);
    rdchk(IDX_MULT_LOW, 32'h0000_0040);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0020);
    tick(40);
    rate(48, 12);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0010);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_MULT_LOW, 32'h0000_0000);
    apb(1'b1, IDX_MULT_HIGH, 32'h0000_0000);
    apb(1'b1, IDX_REF_DIVIDER, 32'h0000_0000);
    rdchk(IDX_MULT_LOW, 32'h0000_0000);
    check(32'(mult_n), 32'h0000_0001);
    check(32'(ref_r), 32'h0000_0001);
    apb(1'b1, IDX_VCO_RANGE, 32'h0000_00D0);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_000D);
    tick(2);
    check(32'(range_e), 32'h0000_0001);
    check(32'(pre_p), 32'h0000_0003);
    check(32'(lin_l), 32'h0000_00D0);
    check(centre, 32'h0000_00D0 * NOM_STEP_HZ * 32'h0000_0002);
    apb(1'b1, IDX_VCO_RANGE, 32'h0000_0000);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0021);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_0031);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0021);
    check({31'h0, pll_en}, 32'h0000_0000);
    lock <= 1'b1;
    tick(3);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0021);
    apb(1'b1, IDX_BANDWIDTH, 32'h0000_0080);
    apb(1'b1, IDX_PLL_CONTROL, 32'h0000_00A1);
    rdchk(IDX_PLL_CONTROL, 32'h0000_00A1);
    rdchk(IDX_BANDWIDTH, 32'h0000_00C0);
    lock <= 1'b0;
    tick(3);
    check({31'h0, irq}, 32'h0000_0001);
    rdchk(IDX_PLL_CONTROL, 32'h0000_00E1);
    rdchk(IDX_PLL_CONTROL, 32'h0000_00A1);
    check({31'h0, irq}, 32'h0000_0000);
    track <= 1'b1;
    tick(2);
    rdchk(IDX_BANDWIDTH, 32'h0000_00A0);
    check({31'h0, acq}, 32'h0000_0001);
    apb(1'b1, IDX_BANDWIDTH, 32'h0000_0000);
    rdchk(IDX_PLL_CONTROL, 32'h0000_0021);
    sysen <= 1'b0;
    tick(3);
    check({31'h0, osc_en}, 32'h0000_0000);
    apb(1'b1, IDX_OSC_CONFIG, 32'h0000_0001);
    tick(2);
    check({31'h0, osc_en}, 32'h0000_0001);
    final_report();
  end
endmodule
